//--- state_control_pdi_config.sv
// Application-layer state handshake and process-interface configuration registers
`timescale 1ns/1ps
`default_nettype none
module state_control_pdi_config (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        netWrite,
    input  wire logic        netRead,
    input  wire logic [11:0] netAddr,
    input  wire logic [1:0]  netByteEn,
    input  wire logic [15:0] netWdata,
    output logic      [15:0] netRdata,
    input  wire logic        ifWrite,
    input  wire logic        ifRead,
    input  wire logic [11:0] ifAddr,
    input  wire logic [1:0]  ifByteEn,
    input  wire logic [15:0] ifWdata,
    output logic      [15:0] ifRdata,
    input  wire logic        configLoad,
    input  wire logic        configValid,
    input  wire logic [7:0]  cfgInterfaceSelect,
    input  wire logic [7:0]  cfgCoreOption,
    input  wire logic [15:0] cfgChipOption,
    input  wire logic [7:0]  cfgInterfaceConfig,
    input  wire logic [15:0] linkStatus,
    input  wire logic        newError,
    input  wire logic [3:0]  autoRunPattern,
    input  wire logic [3:0]  autoErrPattern,
    input  wire logic        frameStart,
    input  wire logic        frameEnd,
    input  wire logic        latchInPin,
    input  wire logic        syncPulse0,
    input  wire logic        syncPulse1,
    input  wire logic        watchdogTriggerPulse,
    input  wire logic        watchdogExpired,
    output logic             appEventRequest,
    output logic             reportEvent,
    output logic             linkStatusEvent,
    output logic             processDataEnable,
    output logic [3:0]       runStateLamp,
    output logic [3:0]       errorLamp,
    output logic [2:0]       interfaceMode,
    output logic [2:0]       enhancedLinkEnable,
    output logic             outputUpdate,
    output logic             inputSample,
    output logic             outputClear,
    output logic             outputValidStrobe,
    output logic             allPinsBidir
);
    logic [15:0] stateRequest;
    logic [15:0] stateReport;
    logic [15:0] errorCode;
    logic [7:0]  runOverride;
    logic [7:0]  errOverride;
    logic [7:0]  ifSelect;
    logic [7:0]  coreOption;
    logic [15:0] chipOption;
    logic [7:0]  ifConfig;
    logic        requestLocked;
    logic        firstLoadDone;
    logic [3:0]  enhLatched;
    logic        configOk;
    logic        latchSync1;
    logic        latchSync2;
    logic        latchPrev;
    logic        wdPending;
    logic        emulation;
    logic        netReqWr;
    logic        ifReqRd;
    logic        reportChange;
    logic [15:0] next_report;
    logic        outEvent;
    logic        inEvent;

    assign emulation = coreOption[state_control_pkg::EMULATION_BIT];
    assign netReqWr  = netWrite && netAddr[11:1] == state_control_pkg::OFS_STATE_REQUEST[11:1]
                       && (emulation || !requestLocked);
    assign ifReqRd   = ifRead && ifAddr[11:1] == state_control_pkg::OFS_STATE_REQUEST[11:1];

    // Mailbox lock
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            requestLocked <= 1'b0;
        else if (netReqWr && !emulation)
            requestLocked <= 1'b1;
        else if (ifReqRd)
            requestLocked <= 1'b0;
    end

    // State request register
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            stateRequest <= state_control_pkg::STATE_REQUEST_RESET;
        else if (netReqWr)
        begin
            if (netByteEn[0])
                stateRequest[7:0] <= netWdata[7:0] & state_control_pkg::STATE_FIELD_MASK[7:0];
        end
    end

    // Next report value
    always_comb
    begin
        next_report = stateReport;
        if (emulation)
        begin
            if (netReqWr && netByteEn[0])
                next_report = {8'h00, netWdata[7:0]} & state_control_pkg::STATE_FIELD_MASK;
        end
        else if (ifWrite && ifAddr[11:1] == state_control_pkg::OFS_STATE_REPORT[11:1] && ifByteEn[0])
            next_report = {8'h00, ifWdata[7:0]} & state_control_pkg::STATE_FIELD_MASK;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            stateReport <= state_control_pkg::STATE_REPORT_RESET;
        else
            stateReport <= next_report;
    end

    always_comb
    begin
        case (next_report[3:0])
            state_control_pkg::ST_INIT,
            state_control_pkg::ST_PREOP,
            state_control_pkg::ST_BOOT,
            state_control_pkg::ST_SAFEOP,
            state_control_pkg::ST_OP: reportChange = next_report != stateReport;
            default:                  reportChange = 1'b0;
        endcase
    end

    // Event flags: set wins over clear
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            appEventRequest <= 1'b0;
        else if (netReqWr)
            appEventRequest <= 1'b1;
        else if (ifReqRd)
            appEventRequest <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            reportEvent <= 1'b0;
        else if (next_report != stateReport)
            reportEvent <= 1'b1;
        else if (netRead && netAddr[11:1] == state_control_pkg::OFS_STATE_REPORT[11:1])
            reportEvent <= 1'b0;
    end

    logic [15:0] linkPrev;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            linkPrev        <= 16'h0000;
            linkStatusEvent <= 1'b0;
        end
        else
        begin
            linkPrev <= linkStatus;
            if (linkStatus != linkPrev)
                linkStatusEvent <= 1'b1;
            else if (netRead && netAddr[11:1] == state_control_pkg::OFS_LINK_STATUS[11:1])
                linkStatusEvent <= 1'b0;
        end
    end

    // Error code, interface writable only
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            errorCode <= 16'h0000;
        else if (ifWrite && ifAddr[11:1] == state_control_pkg::OFS_ERROR_CODE[11:1])
        begin
            if (ifByteEn[0])
                errorCode[7:0] <= ifWdata[7:0];
            if (ifByteEn[1])
                errorCode[15:8] <= ifWdata[15:8];
        end
    end

    // Run override: both sides may write
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            runOverride <= 8'h00;
        else if (reportChange)
            runOverride[state_control_pkg::OVR_ENABLE_BIT] <= 1'b0;
        else if (netWrite && netAddr == state_control_pkg::OFS_RUN_OVERRIDE && netByteEn[0])
            runOverride <= netWdata[7:0] & state_control_pkg::OVERRIDE_MASK;
        else if (ifWrite && ifAddr == state_control_pkg::OFS_RUN_OVERRIDE && ifByteEn[0])
            runOverride <= ifWdata[7:0] & state_control_pkg::OVERRIDE_MASK;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            errOverride <= 8'h00;
        else if (newError)
            errOverride[state_control_pkg::OVR_ENABLE_BIT] <= 1'b0;
        else if (netWrite && netAddr[11:1] == state_control_pkg::OFS_RUN_OVERRIDE[11:1]
                 && netByteEn[1])
            errOverride <= netWdata[15:8] & state_control_pkg::OVERRIDE_MASK;
        else if (ifWrite && ifAddr[11:1] == state_control_pkg::OFS_RUN_OVERRIDE[11:1]
                 && ifByteEn[1])
            errOverride <= ifWdata[15:8] & state_control_pkg::OVERRIDE_MASK;
    end

    // Lamp patterns actually driven
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            runStateLamp <= 4'h0;
            errorLamp    <= 4'h0;
        end
        else
        begin
            runStateLamp <= runOverride[state_control_pkg::OVR_ENABLE_BIT]
                            ? runOverride[3:0] : autoRunPattern;
            errorLamp    <= errOverride[state_control_pkg::OVR_ENABLE_BIT]
                            ? errOverride[3:0] : autoErrPattern;
        end
    end

    // Configuration image load
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ifSelect   <= 8'h00;
            coreOption <= 8'h00;
            chipOption <= 16'h0000;
            ifConfig   <= 8'h00;
            configOk   <= 1'b0;
        end
        else if (configLoad)
        begin
            ifSelect   <= cfgInterfaceSelect;
            coreOption <= cfgCoreOption & ~state_control_pkg::ENH_LINK_MASK;
            chipOption <= cfgChipOption & {state_control_pkg::CHIP_OPT_MASK_HI,
                                           state_control_pkg::CHIP_OPT_MASK_LO};
            ifConfig   <= cfgInterfaceConfig;
            configOk   <= configValid;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            firstLoadDone <= 1'b0;
            enhLatched    <= 4'h0;
        end
        else if (configLoad && !firstLoadDone)
        begin
            firstLoadDone <= 1'b1;
            enhLatched    <= {cfgCoreOption[6:4], cfgCoreOption[state_control_pkg::ALL_PORTS_BIT]};
        end
    end

    assign processDataEnable = configOk;
    assign enhancedLinkEnable = enhLatched[3:1] | {3{enhLatched[0]}};

    always_comb
    begin
        if (ifSelect == state_control_pkg::SEL_DIGITAL_IO)
            interfaceMode = state_control_pkg::MODE_DIGITAL_IO;
        else if (ifSelect == state_control_pkg::SEL_VENDOR_SERIAL)
            interfaceMode = state_control_pkg::MODE_VENDOR_SERIAL;
        else if (ifSelect == state_control_pkg::SEL_SERIAL_A || ifSelect == state_control_pkg::SEL_SERIAL_B)
            interfaceMode = state_control_pkg::MODE_SERIAL;
        else if (ifSelect >= state_control_pkg::SEL_HOST_LO && ifSelect <= state_control_pkg::SEL_HOST_HI)
            interfaceMode = state_control_pkg::MODE_HOST_BUS;
        else if (ifSelect >= state_control_pkg::SEL_DIRECT_LO && ifSelect <= state_control_pkg::SEL_DIRECT_HI)
            interfaceMode = state_control_pkg::MODE_DIRECT_HOST_BUS;
        else
            interfaceMode = state_control_pkg::MODE_SPARE_WORD;
    end

    // Latch input synchroniser
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            latchSync1 <= 1'b0;
            latchSync2 <= 1'b0;
            latchPrev  <= 1'b0;
        end
        else
        begin
            latchSync1 <= latchInPin;
            latchSync2 <= latchSync1;
            latchPrev  <= latchSync2;
        end
    end

    logic digitalIo;
    assign digitalIo = interfaceMode == state_control_pkg::MODE_DIGITAL_IO;

    always_comb
    begin
        if (ifConfig[state_control_pkg::OV_MODE_BIT])
            outEvent = watchdogTriggerPulse;
        else
        begin
            case (ifConfig[state_control_pkg::OUT_SEL_HI:state_control_pkg::OUT_SEL_LO])
                state_control_pkg::SMP_FRAME: outEvent = frameEnd;
                state_control_pkg::SMP_SYNC_PULSE_0: outEvent = syncPulse0;
                state_control_pkg::SMP_SYNC_PULSE_1: outEvent = syncPulse1;
                default:                      outEvent = 1'b0;
            endcase
        end
        case (ifConfig[state_control_pkg::IN_SEL_HI:state_control_pkg::IN_SEL_LO])
            state_control_pkg::SMP_FRAME: inEvent = frameStart;
            state_control_pkg::SMP_LATCH: inEvent = latchSync2 && !latchPrev;
            state_control_pkg::SMP_SYNC_PULSE_0: inEvent = syncPulse0;
            state_control_pkg::SMP_SYNC_PULSE_1: inEvent = syncPulse1;
            default:                      inEvent = 1'b0;
        endcase
    end

    // Watchdog clearing of outputs
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            wdPending <= 1'b0;
        else if (watchdogExpired)
            wdPending <= 1'b1;
        else if (outEvent)
            wdPending <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            outputUpdate      <= 1'b0;
            inputSample       <= 1'b0;
            outputClear       <= 1'b0;
            outputValidStrobe <= 1'b0;
        end
        else
        begin
            outputUpdate <= digitalIo && outEvent;
            inputSample  <= digitalIo && inEvent;
            outputClear  <= digitalIo && (ifConfig[state_control_pkg::WD_BEHAVIOR_BIT]
                            ? (wdPending && outEvent) : watchdogExpired);
            outputValidStrobe <= (digitalIo && outEvent)
                                 ^ ifConfig[state_control_pkg::OV_POLARITY_BIT];
        end
    end

    assign allPinsBidir = digitalIo && ifConfig[state_control_pkg::BIDIR_BIT];

    // Read data, spare_word bits zero
    function automatic logic [15:0] readWord(input logic [11:0] a);
        logic [15:0] r;
        r = 16'h0000;
        case ({a[11:1], 1'b0})
            state_control_pkg::OFS_STATE_REQUEST: r = stateRequest;
            state_control_pkg::OFS_STATE_REPORT:  r = stateReport;
            state_control_pkg::OFS_ERROR_CODE:    r = errorCode;
            state_control_pkg::OFS_RUN_OVERRIDE:  r = {3'h0, errOverride[4], errorLamp,
                                                       3'h0, runOverride[4], runStateLamp};
            state_control_pkg::OFS_IF_SELECT:     r = {coreOption | {1'b0, enhLatched[3:1], 2'h0,
                                                       enhLatched[0], 1'b0}, ifSelect};
            state_control_pkg::OFS_CHIP_OPTION:   r = chipOption;
            state_control_pkg::OFS_IF_CONFIG:     r = {8'h00, ifConfig};
            state_control_pkg::OFS_LINK_STATUS:   r = {linkStatus[15:1], configOk};
            default:                              r = 16'h0000;
        endcase
        return r;
    endfunction

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            netRdata <= 16'h0000;
            ifRdata  <= 16'h0000;
        end
        else
        begin
            netRdata <= readWord(netAddr);
            ifRdata  <= readWord(ifAddr);
        end
    end
endmodule
`default_nettype wire

//--- state_control_pkg.sv
// Offsets, field layouts and reset values of the state control register group
package state_control_pkg;
    localparam logic [11:0] OFS_STATE_REQUEST   = 12'h120;
    localparam logic [11:0] OFS_STATE_REPORT    = 12'h130;
    localparam logic [11:0] OFS_ERROR_CODE      = 12'h134;
    localparam logic [11:0] OFS_RUN_OVERRIDE    = 12'h138;
    localparam logic [11:0] OFS_ERR_OVERRIDE    = 12'h139;
    localparam logic [11:0] OFS_IF_SELECT       = 12'h140;
    localparam logic [11:0] OFS_CORE_OPTION     = 12'h141;
    localparam logic [11:0] OFS_CHIP_OPTION     = 12'h142;
    localparam logic [11:0] OFS_SPARE_WORD      = 12'h144;
    localparam logic [11:0] OFS_IF_CONFIG       = 12'h150;
    localparam logic [11:0] OFS_LINK_STATUS     = 12'h110;
    localparam logic [15:0] STATE_REQUEST_RESET = 16'h0001;
    localparam logic [15:0] STATE_REPORT_RESET  = 16'h0001;
    localparam logic [15:0] STATE_FIELD_MASK    = 16'h001f;
    localparam logic [7:0]  OVERRIDE_MASK       = 8'h1f;
    localparam int          OVR_ENABLE_BIT      = 4;
    localparam int          EMULATION_BIT       = 0;
    localparam int          ALL_PORTS_BIT       = 1;
    localparam int          PORT0_ENH_BIT       = 4;
    localparam logic [7:0]  ENH_LINK_MASK       = 8'h72;
    localparam logic [3:0]  ST_INIT             = 4'h1;
    localparam logic [3:0]  ST_PREOP            = 4'h2;
    localparam logic [3:0]  ST_BOOT             = 4'h3;
    localparam logic [3:0]  ST_SAFEOP           = 4'h4;
    localparam logic [3:0]  ST_OP               = 4'h8;
    localparam logic [7:0]  SEL_DIGITAL_IO      = 8'h04;
    localparam logic [7:0]  SEL_VENDOR_SERIAL   = 8'h05;
    localparam logic [7:0]  SEL_SERIAL_A        = 8'h80;
    localparam logic [7:0]  SEL_SERIAL_B        = 8'h82;
    localparam logic [7:0]  SEL_HOST_LO         = 8'h88;
    localparam logic [7:0]  SEL_HOST_HI         = 8'h8f;
    localparam logic [7:0]  SEL_DIRECT_LO       = 8'h90;
    localparam logic [7:0]  SEL_DIRECT_HI       = 8'h97;
    localparam int          OUT_SEL_HI          = 7;
    localparam int          OUT_SEL_LO          = 6;
    localparam int          IN_SEL_HI           = 5;
    localparam int          IN_SEL_LO           = 4;
    localparam int          WD_BEHAVIOR_BIT     = 3;
    localparam int          BIDIR_BIT           = 2;
    localparam int          OV_MODE_BIT         = 1;
    localparam int          OV_POLARITY_BIT     = 0;
    localparam logic [1:0]  SMP_FRAME           = 2'h0;
    localparam logic [1:0]  SMP_LATCH           = 2'h1;
    localparam logic [1:0]  SMP_SYNC_PULSE_0           = 2'h2;
    localparam logic [1:0]  SMP_SYNC_PULSE_1           = 2'h3;
    localparam logic [7:0]  CHIP_OPT_MASK_HI    = 8'hc0;
    localparam logic [7:0]  CHIP_OPT_MASK_LO    = 8'hc0;
    typedef enum logic [2:0] {
        MODE_SPARE_WORD,
        MODE_DIGITAL_IO,
        MODE_VENDOR_SERIAL,
        MODE_SERIAL,
        MODE_HOST_BUS,
        MODE_DIRECT_HOST_BUS
    } if_mode_t;
endpackage

//--- state_control_pdi_config_properties.sv
// Port assertions, state control group
`timescale 1ns/1ps
`default_nettype none
module state_control_props (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        netWrite,
    input wire logic        netRead,
    input wire logic [11:0] netAddr,
    input wire logic [15:0] netRdata,
    input wire logic        ifWrite,
    input wire logic        ifRead,
    input wire logic [11:0] ifAddr,
    input wire logic [15:0] ifRdata,
    input wire logic        configLoad,
    input wire logic        configValid,
    input wire logic [15:0] linkStatus,
    input wire logic        newError,
    input wire logic        appEventRequest,
    input wire logic        reportEvent,
    input wire logic        linkStatusEvent,
    input wire logic        processDataEnable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    wire netReq = netAddr[11:1] == 11'h090;
    wire netRep = netAddr[11:1] == 11'h098;
    wire netLink = netAddr[11:1] == 11'h088;
    wire ifReq = ifAddr[11:1] == 11'h090;
    wire ifOvr = ifAddr[11:1] == 11'h09c;
    wire anyWr = netWrite || ifWrite;
    a_req_read_clears: assert property (ifRead && ifReq && !netWrite |=> !appEventRequest)
        else $error("event kept");
    a_event_cause: assert property ($rose(appEventRequest) |-> $past(netWrite && netReq))
        else $error("stray event");
    a_report_clear: assert property (netRead && netRep && !anyWr |=> !reportEvent)
        else $error("report event kept");
    a_link_clear: assert property (netRead && netLink && $stable(linkStatus) |=> !linkStatusEvent)
        else $error("link event kept");
    a_load_good: assert property (configLoad && configValid |=> processDataEnable)
        else $error("access not enabled");
    a_load_bad: assert property (configLoad && !configValid |=> !processDataEnable)
        else $error("enabled on bad load");
    a_link_bit: assert property (netRead && netLink && !configLoad |=> netRdata[0] == processDataEnable)
        else $error("status bit differs");
    a_rsvd_zero: assert property (netRead && (netReq || netRep) |=> netRdata[15:5] == 11'h000)
        else $error("spare_word bits set");
    a_spare_zero: assert property (netRead && netAddr[11:1] == 11'h0a2 |=> netRdata == 16'h0000)
        else $error("spare word not zero");
    a_err_ovr_drop: assert property ((newError && !anyWr) ##1 !anyWr ##1 (ifRead && ifOvr && !anyWr) |=> !ifRdata[12])
        else $error("override kept");
    c_lock: cover property (netWrite && netReq ##1 appEventRequest);
    c_report: cover property (reportEvent ##2 !reportEvent);
    c_load: cover property ($rose(processDataEnable));
endmodule
bind state_control_pdi_config state_control_props chk (
    .core_clk, .resetn, .netWrite, .netRead, .netAddr, .netRdata, .ifWrite, .ifRead,
    .ifAddr, .ifRdata, .configLoad, .configValid, .linkStatus, .newError,
    .appEventRequest, .reportEvent, .linkStatusEvent, .processDataEnable
);
`default_nettype wire

//--- port_master_model.sv
// Port master model
`timescale 1ns/1ps
`default_nettype none
module port_master_model (
    input  wire logic        core_clk,
    output logic             wr,
    output logic             rd,
    output logic      [11:0] addr,
    output logic      [1:0]  byteEn,
    output logic      [15:0] wdata,
    input  wire logic [15:0] rdata
);
    initial
    begin
        {wr, rd, addr, byteEn, wdata} = '0;
    end
    task automatic access(input logic w, input logic [11:0] a, input logic [15:0] d,
                          input logic [1:0] be, output logic [15:0] q);
        @(posedge core_clk);
        {wr, rd, addr, wdata, byteEn} <= {w, !w, a, d, be};
        @(posedge core_clk);
        {wr, rd, addr, wdata} <= {2'b00, ~a, ~d};
        @(negedge core_clk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

//--- state_control_pdi_config_tb_top.sv
// Self-checking bench, state control registers
`timescale 1ns/1ps
`default_nettype none
module state_control_pdi_config_tb_top;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic netWrite, netRead, ifWrite, ifRead, configLoad, configValid, newError;
    logic [11:0] netAddr, ifAddr;
    logic [1:0] netByteEn, ifByteEn;
    logic [15:0] netWdata, netRdata, ifWdata, ifRdata, linkStatus, cfgChipOption;
    logic frameStart, frameEnd, latchInPin, syncPulse0, syncPulse1;
    logic watchdogTriggerPulse, watchdogExpired;
    logic [3:0] autoRunPattern, autoErrPattern, runStateLamp, errorLamp;
    logic [2:0] interfaceMode, enhancedLinkEnable;
    logic appEventRequest, reportEvent, linkStatusEvent, processDataEnable;
    logic outputUpdate, inputSample, outputClear, outputValidStrobe, allPinsBidir;
    int nFail = 0;
    int nChecks = 0;
    int seed = 32'h93afa79b;
    logic [15:0] req, rep, code, q, chip;
    logic [7:0] sel, coreRb, enh, ifc, cfgInterfaceSelect, cfgCoreOption, cfgInterfaceConfig;
    logic [3:0] runPat, errPat;
    logic runEn, errEn, emu, locked, pde, first;
    logic [11:0] regList [9] = '{12'h110, 12'h120, 12'h130, 12'h134, 12'h138,
                                 12'h140, 12'h142, 12'h144, 12'h150};
    logic [3:0] stList [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
    logic [7:0] selList [12] = '{8'h05, 8'h80, 8'h82, 8'h88, 8'h8f, 8'h90,
                                 8'h97, 8'h00, 8'h81, 8'h98, 8'hff, 8'h04};
    always #10 core_clk = ~core_clk;
    state_control_pdi_config dut (.*);
    port_master_model netm (.core_clk, .wr(netWrite), .rd(netRead), .addr(netAddr),
                            .byteEn(netByteEn), .wdata(netWdata), .rdata(netRdata));
    port_master_model ifm (.core_clk, .wr(ifWrite), .rd(ifRead), .addr(ifAddr),
                           .byteEn(ifByteEn), .wdata(ifWdata), .rdata(ifRdata));
    always @(posedge core_clk)
        {frameStart, frameEnd, latchInPin, syncPulse0, syncPulse1, watchdogTriggerPulse,
         watchdogExpired} <= 7'($random(seed) & $random(seed));
    task automatic give_verdict();
        if (nFail == 0 && nChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        nChecks++;
        if (g !== e)
        begin
            nFail++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask
    function automatic logic [2:0] modeOf(input logic [7:0] s);
        if (s == 8'h04) modeOf = 3'h1;
        else if (s == 8'h05) modeOf = 3'h2;
        else if (s == 8'h80 || s == 8'h82) modeOf = 3'h3;
        else if (s >= 8'h88 && s <= 8'h8f) modeOf = 3'h4;
        else if (s >= 8'h90 && s <= 8'h97) modeOf = 3'h5;
        else modeOf = 3'h0;
    endfunction
    function automatic logic [15:0] expv(input logic [11:0] a);
        case (a[11:1])
            11'h088: expv = {linkStatus[15:1], pde};
            11'h090: expv = req;
            11'h098: expv = rep;
            11'h09a: expv = code;
            11'h09c: expv = {3'h0, errEn, errEn ? errPat : autoErrPattern,
                             3'h0, runEn, runEn ? runPat : autoRunPattern};
            11'h0a0: expv = {coreRb, sel};
            11'h0a1: expv = chip;
            11'h0a8: expv = {8'h00, ifc};
            default: expv = 16'h0000;
        endcase
    endfunction
    task automatic setRep(input logic [15:0] v);
        if (v != rep)
            runEn = 1'b0;
        rep = v;
    endtask
    task automatic nw(input logic [11:0] a, input logic [15:0] d);
        netm.access(1'b1, a, d, 2'b11, q);
        if (a == 12'h120 && (emu || !locked))
        begin
            req = d & 16'h001f;
            locked = !emu;
            if (emu)
                setRep(req);
        end
    endtask
    task automatic iw(input logic [11:0] a, input logic [15:0] d);
        ifm.access(1'b1, a, d, 2'b11, q);
        if (a == 12'h130 && !emu)
            setRep(d & 16'h001f);
        if (a == 12'h134)
            code = d;
        if (a == 12'h138)
            {errEn, errPat, runEn, runPat} = {d[12:8], d[4:0]};
    endtask
    task automatic nr(input logic [11:0] a);
        netm.access(1'b0, a, 16'h0000, 2'b11, q);
        chk(expv(a), q);
    endtask
    task automatic ir(input logic [11:0] a);
        ifm.access(1'b0, a, 16'h0000, 2'b11, q);
        chk(expv(a), q);
        if (a[11:1] == 11'h090)
            locked = 1'b0;
    endtask
    task automatic cfg(input logic [7:0] s, input logic [7:0] c, input logic v);
        @(posedge core_clk);
        {configLoad, configValid, cfgInterfaceSelect, cfgCoreOption} <= {1'b1, v, s, c};
        @(posedge core_clk);
        configLoad <= 1'b0;
        @(negedge core_clk);
        if (first)
            enh = c & 8'h72;
        first = 1'b0;
        {sel, coreRb, emu, pde, chip, ifc} = {s, enh | c & 8'h01, c[0], v, cfgChipOption & 16'hc0c0,
                                              cfgInterfaceConfig};
        chk({13'h0, modeOf(s)}, {13'h0, interfaceMode});
    endtask
    initial
    begin
        {configLoad, configValid, newError, cfgInterfaceSelect, cfgCoreOption} = '0;
        {frameStart, frameEnd, latchInPin, syncPulse0, syncPulse1, watchdogTriggerPulse, watchdogExpired} = '0;
        cfgChipOption = 16'($random(seed));
        cfgInterfaceConfig = 8'($random(seed));
        linkStatus = 16'($random(seed));
        {autoRunPattern, autoErrPattern} = 8'($random(seed));
        {req, rep, code, sel, coreRb, enh, chip, ifc} = {16'h0001, 16'h0001, 16'h0000, 48'h0};
        {runEn, errEn, runPat, errPat, emu, locked, pde, first} = {10'h0, 4'h1};
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        chk({15'h0, processDataEnable}, 16'h0000);
        foreach (regList[i]) nr(regList[i]);
        cfg(8'h88, 8'h10, 1'b1);
        chk({13'h0, enhancedLinkEnable}, 16'h0001);
        chk({15'h0, allPinsBidir}, 16'h0000);
        foreach (regList[i]) nr(regList[i]);
        nw(12'h120, 16'h0002);
        chk({15'h0, appEventRequest}, 16'h0001);
        nw(12'h120, 16'h0004);
        nr(12'h120);
        ir(12'h121);
        chk({15'h0, appEventRequest}, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            nw(12'h120, {11'h0, i[0], stList[i]});
            ir(12'h120);
        end
        iw(12'h130, 16'hffe4);
        chk({15'h0, reportEvent}, 16'h0001);
        nr(12'h130);
        chk({15'h0, reportEvent}, 16'h0000);
        nr(12'h110);
        chk({15'h0, linkStatusEvent}, 16'h0000);
        iw(12'h134, 16'($random(seed)));
        nw(12'h134, 16'h5a5a);
        nr(12'h134);
        iw(12'h138, 16'($random(seed)) | 16'h1010);
        @(negedge core_clk);
        chk({8'h0, errorLamp, runStateLamp}, {8'h0, errPat, runPat});
        ir(12'h138);
        @(posedge core_clk);
        newError <= 1'b1;
        @(posedge core_clk);
        newError <= 1'b0;
        errEn = 1'b0;
        ir(12'h138);
        cfg(8'h04, 8'h63, 1'b1);
        chk({13'h0, enhancedLinkEnable}, 16'h0001);
        chk({15'h0, allPinsBidir}, {15'h0, cfgInterfaceConfig[2]});
        nr(12'h140);
        nw(12'h120, 16'h0002);
        nw(12'h120, 16'h0008);
        nr(12'h130);
        ir(12'h138);
        iw(12'h130, 16'h0002);
        nr(12'h130);
        foreach (selList[i]) cfg(selList[i], 8'h01, 1'b1);
        cfg(8'h04, 8'h01, 1'b0);
        nr(12'h110);
        give_verdict();
    end
    initial
    begin
        #400000;
        nFail++;
        give_verdict();
    end
endmodule
`default_nettype wire
